/* core/bool_blocks.v */
// Top of the Boolean block library, evaluated on each program cycle strobe.
`timescale 1ns/10ps
`include "bool_blocks_defs.vh"
module bool_blocks (
  input  wire                     CORE_CLK,
  input  wire                     RESET,
  input  wire                     CYCLE_STROBE,
  input  wire                     VARIANT_REDUCED,
  input  wire [`GATE_INPUTS-1:0]  AND_IN,
  input  wire [`GATE_INPUTS-1:0]  AND_USED,
  input  wire [`GATE_INPUTS-1:0]  AND_INV,
  input  wire [`GATE_INPUTS-1:0]  NAND_IN,
  input  wire [`GATE_INPUTS-1:0]  NAND_USED,
  input  wire [`GATE_INPUTS-1:0]  NAND_INV,
  input  wire [`GATE_INPUTS-1:0]  OR_IN,
  input  wire [`GATE_INPUTS-1:0]  OR_USED,
  input  wire [`GATE_INPUTS-1:0]  OR_INV,
  input  wire [`GATE_INPUTS-1:0]  NOR_IN,
  input  wire [`GATE_INPUTS-1:0]  NOR_USED,
  input  wire [`GATE_INPUTS-1:0]  NOR_INV,
  input  wire [`GATE_INPUTS-1:0]  EAND_IN,
  input  wire [`GATE_INPUTS-1:0]  EAND_USED,
  input  wire [`GATE_INPUTS-1:0]  EAND_INV,
  input  wire [`GATE_INPUTS-1:0]  ENAND_IN,
  input  wire [`GATE_INPUTS-1:0]  ENAND_USED,
  input  wire [`GATE_INPUTS-1:0]  ENAND_INV,
  input  wire [`XOR_INPUTS-1:0]   XOR_IN,
  input  wire [`XOR_INPUTS-1:0]   XOR_USED,
  input  wire [`XOR_INPUTS-1:0]   XOR_INV,
  input  wire                     NOT_IN,
  input  wire [`ANALOG_WIDTH-1:0] ANALOG_IN,
  output reg                      AND_OUT,
  output reg                      NAND_OUT,
  output reg                      OR_OUT,
  output reg                      NOR_OUT,
  output reg                      XOR_OUT,
  output reg                      NOT_OUT,
  output reg                      EAND_OUT,
  output reg                      ENAND_OUT,
  output reg  [`ANALOG_WIDTH-1:0] ANALOG_OUT
);
  wire [`GATE_INPUTS-1:0] and_c;
  wire [`GATE_INPUTS-1:0] nand_c;
  wire [`GATE_INPUTS-1:0] or_c;
  wire [`GATE_INPUTS-1:0] nor_c;
  wire [`GATE_INPUTS-1:0] eand_c;
  wire [`GATE_INPUTS-1:0] enand_c;
  wire [`XOR_INPUTS-1:0]  xor_c;
  reg                     eand_all_prev_q;
  reg                     enand_all_prev_q;
  wire                    eand_all;
  wire                    enand_all;

  // Conjunction-type inputs default to one when unused.
  input_condition #(.WIDTH(`GATE_INPUTS), .UNUSED_ONE(1)) u_and (
    .raw(AND_IN), .used(AND_USED), .invert(AND_INV),
    .reduced(VARIANT_REDUCED), .cond(and_c));
  input_condition #(.WIDTH(`GATE_INPUTS), .UNUSED_ONE(1)) u_nand (
    .raw(NAND_IN), .used(NAND_USED), .invert(NAND_INV),
    .reduced(VARIANT_REDUCED), .cond(nand_c));
  input_condition #(.WIDTH(`GATE_INPUTS), .UNUSED_ONE(1)) u_eand (
    .raw(EAND_IN), .used(EAND_USED), .invert(EAND_INV),
    .reduced(VARIANT_REDUCED), .cond(eand_c));
  input_condition #(.WIDTH(`GATE_INPUTS), .UNUSED_ONE(1)) u_enand (
    .raw(ENAND_IN), .used(ENAND_USED), .invert(ENAND_INV),
    .reduced(VARIANT_REDUCED), .cond(enand_c));
  // Disjunction-type inputs default to zero when unused.
  input_condition #(.WIDTH(`GATE_INPUTS), .UNUSED_ONE(0)) u_or (
    .raw(OR_IN), .used(OR_USED), .invert(OR_INV),
    .reduced(VARIANT_REDUCED), .cond(or_c));
  input_condition #(.WIDTH(`GATE_INPUTS), .UNUSED_ONE(0)) u_nor (
    .raw(NOR_IN), .used(NOR_USED), .invert(NOR_INV),
    .reduced(VARIANT_REDUCED), .cond(nor_c));
  // The two-input gate keeps both inputs in either variant.
  input_condition #(.WIDTH(`XOR_INPUTS), .UNUSED_ONE(0)) u_xor (
    .raw(XOR_IN), .used(XOR_USED), .invert(XOR_INV),
    .reduced(1'b0), .cond(xor_c));

  assign eand_all  = &eand_c;
  assign enand_all = &enand_c;

  // All gate outputs update once per program cycle strobe.
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      AND_OUT          <= 1'b0;
      NAND_OUT         <= 1'b1;
      OR_OUT           <= 1'b0;
      NOR_OUT          <= 1'b1;
      XOR_OUT          <= 1'b0;
      NOT_OUT          <= 1'b1;
      EAND_OUT         <= 1'b0;
      ENAND_OUT        <= 1'b0;
      eand_all_prev_q  <= 1'b1;
      enand_all_prev_q <= 1'b0;
      ANALOG_OUT       <= `ANALOG_MIN;
    end else if (CYCLE_STROBE) begin
      AND_OUT   <= &and_c;
      NAND_OUT  <= ~(&nand_c);
      OR_OUT    <= |or_c;
      NOR_OUT   <= ~(|nor_c);
      XOR_OUT   <= xor_c[0] ^ xor_c[1];
      NOT_OUT   <= ~NOT_IN;
      // Rising entry into all-high; one cycle long by construction.
      EAND_OUT  <= eand_all & ~eand_all_prev_q;
      // Leaving the all-high state; also a one-cycle pulse.
      ENAND_OUT <= ~enand_all & enand_all_prev_q;
      eand_all_prev_q  <= eand_all;
      enand_all_prev_q <= enand_all;
      // Analog terminal limits to the accepted range.
      if (ANALOG_IN > `ANALOG_MAX) begin
        ANALOG_OUT <= `ANALOG_MAX;
      end else begin
        ANALOG_OUT <= ANALOG_IN;
      end
    end
  end
endmodule

/* core/bool_blocks_defs.vh */
// Constants for the cycle-evaluated Boolean function block library.
// Notes on behaviour
// - Conjunction output is high only when every input is high.
// - Unconnected conjunction-type inputs, edge variants too, read as one.
// - Unconnected disjunction, negated disjunction, exclusive-or inputs read zero.
// - Edge conjunction fires when all inputs high and one was low last cycle.
// - Edge output is high one cycle, then low at least one cycle.
// - Negated conjunction output is low only when every input is high.
// - Disjunction output is high when any input is high.
// - Negated disjunction output is high only when all inputs are low.
// - Exclusive-or has two inputs; output high when they differ.
// - Negation block outputs the complement of its single input.
// - Each function block input except the negation block's can be inverted individually.
// - Output terminal stages carry no inversion option.
// - Analog output terminal accepts only values from zero to one thousand.
// - Reduced variant uses three inputs and no per-input inversion; exclusive-or keeps both inputs and inversion.
`ifndef BOOL_BLOCKS_DEFS_VH
`define BOOL_BLOCKS_DEFS_VH
`define GATE_INPUTS    4
`define REDUCED_INPUTS 3
`define XOR_INPUTS     2
`define ANALOG_WIDTH   16
`define ANALOG_MIN     16'h0000
`define ANALOG_MAX     16'h03E8
`define VARIANT_FULL    1'b0
`define VARIANT_REDUCED 1'b1
`endif

/* core/input_condition.v */
// Input conditioning for one gate: unused defaulting and per-input inversion.
`timescale 1ns/10ps
module input_condition #(
  parameter WIDTH       = 4,
  parameter UNUSED_ONE  = 1
) (
  input  wire [WIDTH-1:0] raw,
  input  wire [WIDTH-1:0] used,
  input  wire [WIDTH-1:0] invert,
  input  wire             reduced,
  output wire [WIDTH-1:0] cond
);
  genvar i;
  // Each bit: unused inputs take the fixed level, used ones may be inverted.
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      wire active = used[i] & ~(reduced & (i == WIDTH - 1));
      wire inv_en = invert[i] & ~reduced;
      assign cond[i] = active ? (raw[i] ^ inv_en)
                              : (UNUSED_ONE != 0);
    end
  endgenerate
endmodule

/* bench/bool_blocks_chk.sv */
// Checker that ties each gate output to the inputs taken at a strobe; AND_OUT, NAND_OUT, OR_OUT and NOR_OUT only at full-variant strobes.
`timescale 1ns/10ps
module bool_blocks_chk (
  input wire        CORE_CLK, RESET, CYCLE_STROBE, VARIANT_REDUCED,
  input wire [3:0]  AND_IN, AND_USED, AND_INV, NAND_IN, NAND_USED, NAND_INV,
  input wire [3:0]  OR_IN, OR_USED, OR_INV,
  input wire [3:0]  NOR_IN, NOR_USED, NOR_INV,
  input wire [3:0]  EAND_IN, EAND_USED, EAND_INV,
  input wire [3:0]  ENAND_IN, ENAND_USED, ENAND_INV,
  input wire        NOR_OUT, ENAND_OUT,
  input wire [1:0]  XOR_IN, XOR_USED, XOR_INV,
  input wire        NOT_IN, AND_OUT, NAND_OUT, OR_OUT, XOR_OUT, NOT_OUT,
  input wire        EAND_OUT,
  input wire [15:0] ANALOG_IN, ANALOG_OUT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // A strobe of the full variant, where inversion is honoured.
  wire ev = CYCLE_STROBE && !VARIANT_REDUCED;
  // Effective edge-block inputs, reduced variant drops input 3 and inversion.
  wire [3:0] ea_c = VARIANT_REDUCED ?
    {1'b1, EAND_IN[2:0] | ~EAND_USED[2:0]} : (EAND_IN ^ EAND_INV) | ~EAND_USED;
  wire [3:0] en_c = VARIANT_REDUCED ?
    {1'b1, ENAND_IN[2:0] | ~ENAND_USED[2:0]} :
    (ENAND_IN ^ ENAND_INV) | ~ENAND_USED;
  reg ea_prev_q;
  reg en_prev_q;
  // All-high state of each edge block at the previous program cycle.
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ea_prev_q <= 1'b1;
      en_prev_q <= 1'b0;
    end else if (CYCLE_STROBE) begin
      ea_prev_q <= &ea_c;
      en_prev_q <= &en_c;
    end
  end
  nor_func_a: assert property (ev |=> NOR_OUT ==
    ~|$past((NOR_IN ^ NOR_INV) & NOR_USED)) else $error("nor bad");
  edge_and_a: assert property (CYCLE_STROBE |=> EAND_OUT ==
    $past((&ea_c) && !ea_prev_q)) else $error("edge and bad");
  edge_nand_a: assert property (CYCLE_STROBE |=> ENAND_OUT ==
    $past(!(&en_c) && en_prev_q)) else $error("edge nand bad");
  and_func_a: assert property (ev |=> AND_OUT ==
    &$past((AND_IN ^ AND_INV) | ~AND_USED)) else $error("and bad");
  nand_func_a: assert property (ev |=> NAND_OUT ==
    ~&$past((NAND_IN ^ NAND_INV) | ~NAND_USED)) else $error("nand bad");
  or_func_a: assert property (ev |=> OR_OUT ==
    |$past((OR_IN ^ OR_INV) & OR_USED)) else $error("or bad");
  xor_func_a: assert property (CYCLE_STROBE |=> XOR_OUT ==
    ^$past((XOR_IN ^ XOR_INV) & XOR_USED)) else $error("xor bad");
  not_func_a: assert property (CYCLE_STROBE |=>
    NOT_OUT == !$past(NOT_IN)) else $error("not bad");
  edge_pulse_a: assert property (CYCLE_STROBE && EAND_OUT |=>
    !EAND_OUT) else $error("edge pulse too long");
  analog_clamp_a: assert property (CYCLE_STROBE |=> ANALOG_OUT ==
    ($past(ANALOG_IN) > 16'h03E8 ? 16'h03E8 : $past(ANALOG_IN)))
    else $error("analog clamp bad");
  out_hold_a: assert property (!CYCLE_STROBE |=>
    $stable(AND_OUT) && $stable(EAND_OUT)) else $error("output moved");
endmodule
bind bool_blocks bool_blocks_chk bool_blocks_chk_inst (.*);

/* bench/bool_blocks_tb_top.sv */
// Self-checking bench for the Boolean block library.
`timescale 1ns/10ps
module bool_blocks_tb_top;
  logic        CORE_CLK = 0, RESET = 1, CYCLE_STROBE = 0, VARIANT_REDUCED = 0;
  logic [3:0]  AND_IN, AND_USED, AND_INV, NAND_IN, NAND_USED, NAND_INV;
  logic [3:0]  OR_IN, OR_USED, OR_INV, NOR_IN, NOR_USED, NOR_INV;
  logic [3:0]  EAND_IN, EAND_USED, EAND_INV, ENAND_IN, ENAND_USED, ENAND_INV;
  logic [1:0]  XOR_IN, XOR_USED, XOR_INV;
  logic        NOT_IN, AND_OUT, NAND_OUT, OR_OUT, NOR_OUT, XOR_OUT, NOT_OUT;
  logic        EAND_OUT, ENAND_OUT;
  logic [15:0] ANALOG_IN = 16'h0000, ANALOG_OUT;
  wire  [7:0]  outs = {AND_OUT, NAND_OUT, OR_OUT, NOR_OUT, XOR_OUT, NOT_OUT,
                       EAND_OUT, ENAND_OUT};
  int          error_cnt = 0, compares = 0, cyc = 0;
  // Rows: invert, used, level, analog in, gate outputs, analog out.
  logic [49:0] rows [7] = '{{12'h0FF, 16'h0000, 6'h28, 16'h0000},
    {12'h0F0, 16'h03E7, 6'h15, 16'h03E7}, {12'h000, 16'h03E8, 6'h25, 16'h03E8},
    {12'hFF0, 16'h03E9, 6'h29, 16'h03E8}, {12'h0F1, 16'hFFFF, 6'h1A, 16'h03E8},
    {12'h032, 16'h0001, 6'h1B, 16'h0001}, {12'h0EE, 16'h8000, 6'h2B, 16'h03E8}};
  // Edge rows: inputs, then the expected edge and negated edge outputs.
  logic [13:0] edg [4] = '{{12'h0F0, 2'h1}, {12'h0F0, 2'h0},
    {12'h0FF, 2'h2}, {12'h0FF, 2'h0}};
  always #25 CORE_CLK = ~CORE_CLK;
  // A hang is cut short long after the sequence should have ended.
  always @(posedge CORE_CLK) if (++cyc == 3000) begin
    error_cnt++;
    results();
  end
  bool_blocks bool_blocks_inst (.*);
  // The four-input gates see the same levels, use flags and invert flags; XOR takes their low two bits, NOT only level bit 0.
  task automatic drv(input logic [11:0] s);
    {AND_IN, NAND_IN, OR_IN, NOR_IN, EAND_IN, ENAND_IN} = {6{s[3:0]}};
    {AND_USED, NAND_USED, OR_USED, NOR_USED, EAND_USED, ENAND_USED} =
      {6{s[7:4]}};
    {AND_INV, NAND_INV, OR_INV, NOR_INV, EAND_INV, ENAND_INV} = {6{s[11:8]}};
    {XOR_IN, XOR_USED, XOR_INV, NOT_IN} = {s[1:0], s[5:4], s[9:8], s[0]};
  endtask
  task automatic ap(input logic [11:0] s);
    @(negedge CORE_CLK) drv(s);
    CYCLE_STROBE = 1;
    @(negedge CORE_CLK) CYCLE_STROBE = 0;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (e !== g) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    drv(12'h000);
    repeat (16) @(negedge CORE_CLK);
    chk("reset", 16'h0054, outs);
    RESET = 0;
    foreach (rows[i]) begin
      ANALOG_IN = rows[i][37:22];
      ap(rows[i][49:38]);
      chk("gates", rows[i][21:16], outs[7:2]);
      chk("analog", rows[i][15:0], ANALOG_OUT);
    end
    foreach (edg[i]) begin
      ap(edg[i][13:2]);
      chk("edge", edg[i][1:0], outs[1:0]);
    end
    VARIANT_REDUCED = 1;
    ap(12'hFF7);
    chk("reduced", 16'h0028, outs[7:2]);
    RESET = 1;
    @(negedge CORE_CLK);
    chk("reset", 16'h0054, outs);
    RESET = 0;
    ap(12'h0FF);
    chk("edge", 16'h0000, outs[1:0]);
    results();
  end
endmodule
